// file: hw/ast_consts.vh
`ifndef AST_CONSTS_VH
`define AST_CONSTS_VH
// register addresses (byte offsets on the local port)
`define AST_ADDR_TX_CTRL   4'h0
`define AST_ADDR_RX_CTRL   4'h1
`define AST_ADDR_TX_DATA   4'h2
`define AST_ADDR_RX_DATA   4'h3
`define AST_ADDR_BAUD_LO   4'h4
`define AST_ADDR_BAUD_HI   4'h5
`define AST_ADDR_IRQ_CTRL  4'h6
`define AST_ADDR_PINS      4'h7
// tx_status_control fields
`define AST_TX_NINE_EN     6
`define AST_TX_EN          5
`define AST_TX_SYNC        4
`define AST_TX_BRG16       3
`define AST_TX_SHIFT_EMPTY 1
`define AST_TX_NINTH       0
// rx_status_control fields
`define AST_RX_PORT_EN     7
`define AST_RX_NINE_EN     6
`define AST_RX_EN          4
`define AST_RX_FERR        2
`define AST_RX_OERR        1
`define AST_RX_NINTH       0
// irq control fields
`define AST_IRQ_GLOBAL     7
`define AST_IRQ_PERIPH     6
`define AST_IRQ_TX_EN      4
`define AST_IRQ_TX_FLAG    1
`define AST_IRQ_RX_FLAG    0
// reset values
`define AST_TX_CTRL_RST    8'h02
`define AST_BAUD_RST       16'h0000
// timing: instruction cycle is four system clocks
`define AST_ICYC_CLKS      4
`define AST_OVERSAMPLE     16
`define AST_HALF_BIT       8
`endif

// file: hw/ast_transceiver.v
// Contract
// - tx line idles high; NRZ data bits, mark is 1, space is 0
// - frame is start bit low, 8 or 9 data bits, stop bit high
// - every bit lasts one baud period
// - data bits go out and come in lsb first
// - shared format and baud; no parity hardware, ninth bit carries it
// - baud from generator on system clock, 8-bit or 16-bit divider
// - async transmit only with tx enable, sync clear, port enable
// - port and tx enable force transmit pin to output
// - port and rx enable force receive pin to input
// - write with empty shift register loads shift register at once
// - otherwise wait in holding buffer, load one instruction cycle after stop
// - loaded character is sent at once, bits back to back
// - buffer-empty flag high when enabled and holding buffer empty; read only
// - buffer-empty flag clears on second instruction cycle after write
// - flag ignores irq enable; irq needs tx, peripheral and global enables
// - setting tx enable sets buffer-empty flag at once
// - shift-empty status 1 when shift register empty, clear while sending
// - nine-bit mode sends ninth bit as msb; software writes it first
// - receive recovery runs at sixteen times baud
// - received character enters two-entry fifo read through data register
// - start edge rechecked at half bit; high line abandons silently
// - third character with fifo full sets overrun, blocks until rx cleared
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "ast_consts.vh"
module ast_transceiver #(
  parameter ICYC = `AST_ICYC_CLKS
) (
  // clock and reset
  input  wire       ref_clk,
  input  wire       reset_n,
  // register port
  input  wire [3:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // pins
  input  wire       receive_pin_in,
  output wire       transmit_pin_out,
  output wire       transmit_pin_oe,
  output wire       receive_pin_oe,
  input  wire       port_direction_tx,
  input  wire       port_direction_rx,
  input  wire       port_latch_tx,
  // interrupt request
  output wire       tx_irq
);
  localparam TX_IDLE  = 2'd0;
  localparam TX_SHIFT = 2'd1;
  localparam RX_IDLE  = 2'd0;
  localparam RX_START = 2'd1;
  localparam RX_DATA  = 2'd2;
  localparam RX_STOP  = 2'd3;

  // counts kept as full words, cut where used
  localparam [31:0] FLAG_LOAD = 2 * ICYC - 1;
  localparam [31:0] HALF_M1   = `AST_HALF_BIT - 1;
  localparam [31:0] OS_LAST   = `AST_OVERSAMPLE - 1;

  // control registers
  reg  [7:0]  tx_ctrl_q;
  reg  [7:0]  rx_ctrl_q;
  reg  [15:0] baud_q;
  reg  [2:0]  irq_ctrl_q;
  wire serial_port_enable = rx_ctrl_q[`AST_RX_PORT_EN];
  wire tx_enable_bit      = tx_ctrl_q[`AST_TX_EN];
  wire rx_enable_bit      = rx_ctrl_q[`AST_RX_EN];
  wire sync_mode          = tx_ctrl_q[`AST_TX_SYNC];
  wire tx_nine_bit_enable = tx_ctrl_q[`AST_TX_NINE_EN];
  wire rx_nine_bit_enable = rx_ctrl_q[`AST_RX_NINE_EN];
  wire tx_active = tx_enable_bit & ~sync_mode & serial_port_enable;
  wire rx_active = rx_enable_bit & ~sync_mode & serial_port_enable;

  // pin direction overrides
  assign transmit_pin_oe = tx_active | ~port_direction_tx;
  assign receive_pin_oe  = rx_active ? 1'b0 : ~port_direction_rx;

  // receive pin synchroniser
  reg rx_s1_q;
  reg rx_s2_q;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= receive_pin_in;
      rx_s2_q <= rx_s1_q;
    end
  end

  // baud generator: 16x tick; 8-bit or 16-bit divider
  reg  [15:0] brg_cnt_q;
  wire [15:0] brg_div = tx_ctrl_q[`AST_TX_BRG16] ? baud_q :
                        {8'h00, baud_q[7:0]};
  wire        os_tick = (brg_cnt_q == 16'h0000);
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n)
      brg_cnt_q <= 16'h0000;
    else if (os_tick)
      brg_cnt_q <= brg_div;
    else
      brg_cnt_q <= brg_cnt_q - 16'h0001;
  end

  // transmit tick: one per sixteen oversample ticks, shared rate
  reg  [3:0] tx_os_q;
  wire       tx_bit_tick = os_tick & (tx_os_q == OS_LAST[3:0]);
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n)
      tx_os_q <= 4'h0;
    else if (os_tick)
      tx_os_q <= tx_os_q + 4'h1;
  end

  // register writes
  wire wr_tx_data = reg_wr & (reg_addr == `AST_ADDR_TX_DATA);
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_ctrl_q  <= `AST_TX_CTRL_RST;
      rx_ctrl_q  <= 8'h00;
      baud_q     <= `AST_BAUD_RST;
      irq_ctrl_q <= 3'h0;
    end else if (reg_wr) begin
      if (reg_addr == `AST_ADDR_TX_CTRL)
        tx_ctrl_q <= reg_wdata;
      else if (reg_addr == `AST_ADDR_RX_CTRL)
        rx_ctrl_q <= {reg_wdata[7:3], 3'b000};
      else if (reg_addr == `AST_ADDR_BAUD_LO)
        baud_q[7:0] <= reg_wdata;
      else if (reg_addr == `AST_ADDR_BAUD_HI)
        baud_q[15:8] <= reg_wdata;
      else if (reg_addr == `AST_ADDR_IRQ_CTRL)
        irq_ctrl_q <= {reg_wdata[`AST_IRQ_GLOBAL],
                       reg_wdata[`AST_IRQ_PERIPH],
                       reg_wdata[`AST_IRQ_TX_EN]};
    end
  end

  // transmitter
  reg [8:0] tx_holding_buffer_q;
  reg       hold_full_q;
  reg [9:0] tx_shift_reg_q;
  reg [3:0] tx_bits_q;
  reg [1:0] tx_state_q;
  reg       tx_line_q;
  reg [7:0] icyc_cnt_q;
  reg       flag_busy_q;
  reg [7:0] flag_cnt_q;
  wire      shift_empty_status = (tx_state_q == TX_IDLE) &
                                 (icyc_cnt_q == 8'h00);
  wire [9:0] load_word = tx_nine_bit_enable ?
    {tx_holding_buffer_q, 1'b0} :
    {1'b1, tx_holding_buffer_q[7:0], 1'b0};
  wire [3:0] frame_bits = tx_nine_bit_enable ? 4'd11 : 4'd10;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_holding_buffer_q <= 9'h000;
      hold_full_q         <= 1'b0;
      tx_shift_reg_q      <= 10'h3FF;
      tx_bits_q           <= 4'h0;
      tx_state_q          <= TX_IDLE;
      tx_line_q           <= 1'b1;
      icyc_cnt_q          <= 8'h00;
    end else if (!tx_active) begin
      hold_full_q <= 1'b0;
      tx_state_q  <= TX_IDLE;
      tx_line_q   <= 1'b1;
      icyc_cnt_q  <= 8'h00;
    end else begin
      if (wr_tx_data) begin
        tx_holding_buffer_q <= {tx_ctrl_q[`AST_TX_NINTH], reg_wdata};
        hold_full_q         <= 1'b1;
      end
      case (tx_state_q)
        TX_IDLE: begin
          if (icyc_cnt_q != 8'h00)
            icyc_cnt_q <= icyc_cnt_q - 8'h01;
          else if (hold_full_q && !wr_tx_data) begin
            tx_shift_reg_q <= load_word;
            tx_bits_q      <= frame_bits;
            hold_full_q    <= 1'b0;
            tx_state_q     <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (tx_bit_tick) begin
            if (tx_bits_q == 4'h0) begin
              tx_line_q  <= 1'b1;
              tx_state_q <= TX_IDLE;
              icyc_cnt_q <= ICYC[7:0];
            end else begin
              tx_line_q      <= tx_shift_reg_q[0];
              tx_shift_reg_q <= {1'b1, tx_shift_reg_q[9:1]};
              tx_bits_q      <= tx_bits_q - 4'h1;
            end
          end
        end
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end
  assign transmit_pin_out = tx_active ? tx_line_q : port_latch_tx;

  // buffer-empty flag delayed two instruction cycles after a write
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_busy_q <= 1'b0;
      flag_cnt_q  <= 8'h00;
    end else if (!tx_active) begin
      flag_busy_q <= 1'b0;
      flag_cnt_q  <= 8'h00;
    end else if (wr_tx_data) begin
      flag_busy_q <= 1'b0;
      flag_cnt_q  <= FLAG_LOAD[7:0];
    end else if (flag_cnt_q != 8'h00) begin
      flag_cnt_q <= flag_cnt_q - 8'h01;
      if (flag_cnt_q == 8'h01)
        flag_busy_q <= hold_full_q;
    end else
      flag_busy_q <= hold_full_q;
  end
  wire tx_buffer_empty_flag = tx_active & ~flag_busy_q;
  assign tx_irq = tx_buffer_empty_flag & irq_ctrl_q[0] &
                  irq_ctrl_q[1] & irq_ctrl_q[2];

  // receiver
  reg [1:0] rx_state_q;
  reg [3:0] rx_os_q;
  reg [3:0] rx_bits_q;
  reg [8:0] rx_shift_reg_q;
  reg [9:0] fifo_q [0:1];
  reg       fifo_cnt_hi_q;
  reg       fifo_cnt_lo_q;
  reg       rx_oerr_q;
  wire [1:0] fifo_cnt = {fifo_cnt_hi_q, fifo_cnt_lo_q};
  wire [3:0] rx_nbits = rx_nine_bit_enable ? 4'd9 : 4'd8;
  wire       rd_rx   = reg_rd & (reg_addr == `AST_ADDR_RX_DATA) &
                       (fifo_cnt != 2'd0);
  reg        push;
  reg  [9:0] push_word;
  always @* begin
    push      = 1'b0;
    push_word = {~rx_s2_q, rx_shift_reg_q};
    if (rx_state_q == RX_STOP && os_tick && rx_os_q == OS_LAST[3:0])
      push = 1'b1;
  end
  wire accept = push & (fifo_cnt != 2'd2) & ~rx_oerr_q;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_state_q     <= RX_IDLE;
      rx_os_q        <= 4'h0;
      rx_bits_q      <= 4'h0;
      rx_shift_reg_q <= 9'h000;
      rx_oerr_q      <= 1'b0;
    end else if (!rx_active) begin
      rx_state_q <= RX_IDLE;
      rx_oerr_q  <= 1'b0;
    end else begin
      if (push && fifo_cnt == 2'd2)
        rx_oerr_q <= 1'b1;
      case (rx_state_q)
        RX_IDLE: if (!rx_s2_q && !rx_oerr_q) begin
          rx_state_q <= RX_START;
          rx_os_q    <= 4'h0;
        end
        RX_START: if (os_tick) begin
          rx_os_q <= rx_os_q + 4'h1;
          if (rx_os_q == HALF_M1[3:0]) begin
            rx_os_q <= 4'h0;
            if (rx_s2_q)
              rx_state_q <= RX_IDLE;
            else begin
              rx_state_q <= RX_DATA;
              rx_bits_q  <= 4'h0;
            end
          end
        end
        RX_DATA: if (os_tick) begin
          rx_os_q <= rx_os_q + 4'h1;
          if (rx_os_q == OS_LAST[3:0]) begin
            rx_shift_reg_q <= rx_nine_bit_enable ?
              {rx_s2_q, rx_shift_reg_q[8:1]} :
              {1'b0, rx_s2_q, rx_shift_reg_q[7:1]};
            rx_bits_q <= rx_bits_q + 4'h1;
            if (rx_bits_q == rx_nbits - 4'h1)
              rx_state_q <= RX_STOP;
          end
        end
        RX_STOP: if (os_tick) begin
          rx_os_q <= rx_os_q + 4'h1;
          if (rx_os_q == OS_LAST[3:0])
            rx_state_q <= RX_IDLE;
        end
        default: rx_state_q <= RX_IDLE;
      endcase
    end
  end

  // write slot and next value of each fifo entry
  wire       fifo_wr_hi = fifo_cnt_hi_q | (fifo_cnt_lo_q & ~rd_rx);
  wire [1:0] fifo_cnt_d = fifo_cnt + {1'b0, accept} -
                          {1'b0, rd_rx};
  wire [9:0] fifo_d [0:1];
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : fifo_entry
      wire [9:0] kept = (g == 0 && rd_rx) ? fifo_q[1] :
                        fifo_q[g];
      assign fifo_d[g] = (accept && (fifo_wr_hi == (g == 1))) ?
                         push_word : kept;
    end
  endgenerate

  // two-entry receive fifo
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fifo_cnt_hi_q <= 1'b0;
      fifo_cnt_lo_q <= 1'b0;
      fifo_q[0]     <= 10'h000;
      fifo_q[1]     <= 10'h000;
    end else if (!serial_port_enable) begin
      fifo_cnt_hi_q <= 1'b0;
      fifo_cnt_lo_q <= 1'b0;
      fifo_q[0]     <= 10'h000;
    end else begin
      fifo_q[0]                      <= fifo_d[0];
      fifo_q[1]                      <= fifo_d[1];
      {fifo_cnt_hi_q, fifo_cnt_lo_q} <= fifo_cnt_d;
    end
  end

  // readback words
  wire [7:0] tx_ctrl_rd = {tx_ctrl_q[7:2], shift_empty_status,
                           tx_ctrl_q[0]};
  wire [7:0] rx_ctrl_rd = {rx_ctrl_q[7:3], fifo_q[0][9], rx_oerr_q,
                           fifo_q[0][8]};
  wire [7:0] irq_rd     = {irq_ctrl_q[2], irq_ctrl_q[1], 1'b0,
                           irq_ctrl_q[0], 2'b00, tx_buffer_empty_flag,
                           (fifo_cnt != 2'd0)};
  wire [7:0] pins_rd    = {6'h00, transmit_pin_out, rx_s2_q};

  // register reads
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (reg_rd) begin
      if (reg_addr == `AST_ADDR_TX_CTRL)
        reg_rdata <= tx_ctrl_rd;
      else if (reg_addr == `AST_ADDR_RX_CTRL)
        reg_rdata <= rx_ctrl_rd;
      else if (reg_addr == `AST_ADDR_RX_DATA)
        reg_rdata <= fifo_q[0][7:0];
      else if (reg_addr == `AST_ADDR_BAUD_LO)
        reg_rdata <= baud_q[7:0];
      else if (reg_addr == `AST_ADDR_BAUD_HI)
        reg_rdata <= baud_q[15:8];
      else if (reg_addr == `AST_ADDR_IRQ_CTRL)
        reg_rdata <= irq_rd;
      else if (reg_addr == `AST_ADDR_PINS)
        reg_rdata <= pins_rd;
      else
        reg_rdata <= 8'h00;
    end
  end
endmodule // ast_transceiver

// file: sim/ast_transceiver_sva.sv
`timescale 1ns/10ps
module ast_transceiver_sva (
  // clock and reset
  input wire       ref_clk,
  input wire       reset_n,
  // register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  // pins and request
  input wire       transmit_pin_out,
  input wire       transmit_pin_oe,
  input wire       receive_pin_oe,
  input wire       port_latch_tx,
  input wire       tx_irq
);
  // shadow of written registers, run length of tx line level
  reg  [7:0]  sh_q [0:7];
  reg         pin_q;
  reg  [31:0] run_q;
  wire        tx_act = sh_q[1][7] & sh_q[0][5] & ~sh_q[0][4];
  wire        rx_act = sh_q[1][7] & sh_q[1][4] & ~sh_q[0][4];
  wire        irq_on = sh_q[6][7] & sh_q[6][6] & sh_q[6][4];
  wire [15:0] div = sh_q[0][3] ? {sh_q[5], sh_q[4]} : {8'h00, sh_q[4]};
  wire [31:0] bitp = {12'h000, div + 16'h0001, 4'h0};
  wire        idle = tx_act & transmit_pin_out & (run_q > bitp * 11);
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 8; i++) sh_q[i] <= 8'h00;
      pin_q <= 1'h1;
      run_q <= 32'h0;
    end else begin
      if (reg_wr && !reg_addr[3]) sh_q[reg_addr[2:0]] <= reg_wdata;
      pin_q <= transmit_pin_out;
      run_q <= (transmit_pin_out != pin_q) ? 32'h1 : run_q + 32'h1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_tx_forced_out:
    assert property (tx_act |-> transmit_pin_oe) else $error("tx pin not out");
  a_rx_forced_in:
    assert property (rx_act |-> !receive_pin_oe) else $error("rx pin driven");
  a_tx_off_latch:
    assert property (!tx_act |-> transmit_pin_out == port_latch_tx)
      else $error("tx pin not latch");
  a_bit_length:
    assert property (tx_act && transmit_pin_out && !pin_q |->
      run_q % bitp == 32'h0) else $error("bit length wrong");
  a_low_run_max:
    assert property (tx_act && !transmit_pin_out && !pin_q |->
      run_q < bitp * (sh_q[0][6] ? 10 : 9)) else $error("no stop bit");
  a_idle_start:
    assert property (reg_wr && reg_addr == 4'h2 && idle |->
      ##[1:80] !transmit_pin_out) else $error("start bit late");
  a_irq_gated:
    assert property (tx_irq |-> irq_on && tx_act) else $error("irq ungated");
  a_irq_on_enable:
    assert property ($rose(tx_act) && irq_on |-> ##[0:2] tx_irq)
      else $error("flag not set");
endmodule // ast_transceiver_sva
bind ast_transceiver ast_transceiver_sva chk (
  .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .transmit_pin_out(transmit_pin_out), .transmit_pin_oe(transmit_pin_oe),
  .receive_pin_oe(receive_pin_oe), .port_latch_tx(port_latch_tx),
  .tx_irq(tx_irq));

// file: sim/ast_remote_model.sv
`timescale 1ns/10ps
module ast_remote_model (
  // clock and lines
  input wire ref_clk,
  input wire tx_line,
  output reg rx_line
);
  int       bitp = 16;
  bit       nine = 1'b0;
  reg [9:0] got_q [$];
  initial rx_line = 1'h1;
  // start, data lsb first, one stop
  task automatic send(input [8:0] d, input int nb);
    rx_line <= 1'h0;
    repeat (bitp) @(posedge ref_clk);
    for (int i = 0; i < nb; i++) begin
      rx_line <= d[i];
      repeat (bitp) @(posedge ref_clk);
    end
    rx_line <= 1'h1;
    repeat (bitp) @(posedge ref_clk);
  endtask
  // short low pulse, no frame
  task automatic glitch;
    rx_line <= 1'h0;
    repeat (bitp / 4) @(posedge ref_clk);
    rx_line <= 1'h1;
    repeat (bitp) @(posedge ref_clk);
  endtask
  // decode at bit centres, stop kept in bit 9
  always begin : decode
    reg [9:0] d;
    @(negedge tx_line);
    d = 10'h000;
    repeat (bitp / 2) @(posedge ref_clk);
    for (int i = 0; i < (nine ? 10 : 9); i++) begin
      repeat (bitp) @(posedge ref_clk);
      d[i] = tx_line;
    end
    if (!nine) d[9:8] = {d[8], 1'h0};
    got_q.push_back(d);
  end
endmodule // ast_remote_model

// file: sim/ast_transceiver_tb.sv
`timescale 1ns/10ps
module ast_transceiver_tb;
  localparam int IC = 4;
  // clock, reset, register port
  reg        ref_clk = 1'h0;
  reg        reset_n = 1'h0;
  reg  [3:0] reg_addr = 4'h0;
  reg  [7:0] reg_wdata = 8'h00;
  reg        reg_wr = 1'h0;
  reg        reg_rd = 1'h0;
  wire [7:0] reg_rdata;
  // pins
  reg        dir_tx = 1'h1;
  reg        dir_rx = 1'h0;
  reg        latch_tx = 1'h1;
  wire       tx_line, tx_oe, rx_oe, tx_irq, rx_line;
  int        mismatches = 0;
  int        comparisons = 0;
  int        cyc = 0;
  bit        nine;
  reg  [8:0] row [0:5] = '{9'h000, 9'h0FF, 9'h0A5, 9'h001, 9'h155, 9'h0C3};
  always #4 ref_clk = ~ref_clk;
  ast_transceiver #(.ICYC(IC)) uut (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .receive_pin_in(rx_line),
    .transmit_pin_out(tx_line), .transmit_pin_oe(tx_oe),
    .receive_pin_oe(rx_oe), .port_direction_tx(dir_tx),
    .port_direction_rx(dir_rx), .port_latch_tx(latch_tx), .tx_irq(tx_irq));
  ast_remote_model rm (.ref_clk(ref_clk), .tx_line(tx_line),
    .rx_line(rx_line));
  task automatic chk(input [9:0] g, input [9:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input [3:0] a, input [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
    @(posedge ref_clk);
  endtask
  task automatic rdc(input [3:0] a, input [7:0] m, input [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1 chk(reg_rdata & m, e);
    @(posedge ref_clk);
  endtask
  task automatic wait_q(input int n);
    for (int i = 0; i < 3000 && rm.got_q.size() < n; i++) @(posedge ref_clk);
  endtask
  task automatic tally_and_finish;
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'h1;
    @(posedge ref_clk);
    wr(4'h4, 8'h00);
    for (int i = 0; i < 6; i++) begin
      nine = i > 3;
      rm.nine = nine;
      wr(4'h1, {1'h1, nine, 1'h0, 1'h1, 4'h0});
      wr(4'h0, {1'h0, nine, 1'h1, 4'h0, row[i][8]});
      wr(4'h2, row[i][7:0]);
      wait_q(1);
      chk(rm.got_q.pop_front(), {1'h1, row[i]});
      rm.send(row[i], nine ? 9 : 8);
      rdc(4'h1, 8'h07, {7'h00, row[i][8]});
      rdc(4'h3, 8'hFF, row[i][7:0]);
    end
    // flag and request gating
    rm.nine = 1'b0;
    wr(4'h6, 8'hD0);
    chk(tx_irq, 10'h1);
    wr(4'h6, 8'h50);
    rdc(4'h6, 8'h02, 8'h02);
    chk(tx_irq, 10'h0);
    wr(4'h6, 8'hD0);
    wr(4'h0, 8'h00);
    rdc(4'h6, 8'h02, 8'h00);
    wr(4'h0, 8'h20);
    rdc(4'h6, 8'h02, 8'h02);
    // back to back characters
    wr(4'h2, 8'h3C);
    wr(4'h2, 8'hC3);
    rdc(4'h6, 8'h02, 8'h02);
    wr(4'h6, 8'hC0);
    repeat (2 * IC) @(posedge ref_clk);
    rdc(4'h6, 8'h02, 8'h00);
    rdc(4'h0, 8'h02, 8'h00);
    wait_q(2);
    chk(rm.got_q.pop_front(), 10'h23C);
    chk(rm.got_q.pop_front(), 10'h2C3);
    repeat (40) @(posedge ref_clk);
    rdc(4'h0, 8'h02, 8'h02);
    rdc(4'h6, 8'h02, 8'h02);
    // port disabled in mid frame
    wr(4'h2, 8'h00);
    repeat (40) @(posedge ref_clk);
    wr(4'h1, 8'h10);
    rdc(4'h0, 8'h02, 8'h02);
    latch_tx <= 1'h0;
    repeat (3) @(posedge ref_clk);
    latch_tx <= 1'h1;
    repeat (200) @(posedge ref_clk);
    rm.got_q.delete();
    wr(4'h1, 8'h90);
    // false start, then overrun
    rm.glitch();
    for (int i = 0; i < 3; i++) rm.send(9'h011 << i, 8);
    rdc(4'h1, 8'h02, 8'h02);
    rdc(4'h3, 8'hFF, 8'h11);
    rdc(4'h3, 8'hFF, 8'h22);
    rm.send(9'h077, 8);
    rdc(4'h6, 8'h01, 8'h00);
    wr(4'h1, 8'h80);
    wr(4'h1, 8'h90);
    rdc(4'h1, 8'h02, 8'h00);
    rm.send(9'h05A, 8);
    rdc(4'h3, 8'hFF, 8'h5A);
    // slower divider, high byte ignored in 8-bit mode
    wr(4'h5, 8'h01);
    wr(4'h4, 8'h01);
    rm.bitp = 32;
    wr(4'h2, 8'h96);
    wait_q(1);
    chk(rm.got_q.pop_front(), 10'h296);
    rm.send(9'h069, 8);
    rdc(4'h3, 8'hFF, 8'h69);
    // second reset
    reset_n <= 1'h0;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'h1;
    @(posedge ref_clk);
    rdc(4'h0, 8'hFF, 8'h02);
    rdc(4'h9, 8'hFF, 8'h00);
    rdc(4'h6, 8'h02, 8'h00);
    tally_and_finish;
  end
endmodule // ast_transceiver_tb
